// [hdl/spfc_top.sv]
/*
 self-programming flash control: control register, command arming, section busy
 tracking, boot lock bits, lock/fuse readback, interrupts and reset vector choice.
 assumes a classic wishbone master, store/load op pulses from the core and fuses
 that are stable inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module spfc_top #(
   parameter int          PROG_CYCLES = 16,
   parameter logic [15:0] BOOT_VECTOR = 16'h0c00,
   parameter logic [15:0] SECTION_END = 16'h1800
) (
   input  wire logic                      mclk,
   input  wire logic                      reset,
   input  wire logic                      wbCyc,
   input  wire logic                      wbStb,
   input  wire logic                      wbWe,
   input  wire logic [spfc_pkg::WB_AW-1:0] wbAdr,
   input  wire logic [3:0]                wbSel,
   input  wire logic [spfc_pkg::WB_DW-1:0] wbDatIn,
   output logic [spfc_pkg::WB_DW-1:0]     wbDatOut,
   output logic                           wbAck,
   input  wire logic                      storeOp,
   input  wire logic                      loadOp,
   input  wire logic                      globalIrqEnable,
   input  wire logic                      bootResetFuse,
   input  wire logic [7:0]                fuseByte,
   output logic [7:0]                     loadData,
   output logic                           loadValid,
   output logic                           pageWriteStart,
   output logic                           pageEraseStart,
   output logic                           bufferLoad,
   output logic                           bufferDiscard,
   output logic                           sectionAccessEnable,
   output logic [15:0]                    resetVector,
   output logic                           irq
);
   import spfc_pkg::*;

   spfc_state_t      state_r, state_nxt;
   logic [4:0]       cmd_r, cmd_nxt;
   logic             readyIe_r, readyIe_nxt, busy_r, busy_nxt, loading_r, loading_nxt;
   logic [3:0]       lock_r, lock_nxt;
   logic [7:0]       lowData_r, lowData_nxt, highData_r, highData_nxt;
   logic [15:0]      pointer_r, pointer_nxt, vector_r, vector_nxt;
   logic [EV_W-1:0]  stat_r, stat_nxt, mask_r, mask_nxt, events;
   logic [7:0]       load_r, load_nxt;
   logic             loadV_r, loadV_nxt, wr_r, wr_nxt, er_r, er_nxt, bl_r, bl_nxt, bd_r, bd_nxt;
   logic             ack_r, ack_nxt, vecDone_r, vecDone_nxt;
   logic [WB_DW-1:0] dat_r, dat_nxt;
   logic             wbWrite, ctrlWrite, armStart, armStop, armOpen, progStart, progBusy, progDone;
   logic [AGE_W-1:0] armAge;
   logic [7:0]       ctrlRead;

   // wishbone write takes effect on the edge that carries ack
   assign wbWrite   = wbCyc & wbStb & wbWe & ack_r & wbSel[0];
   assign ctrlWrite = wbWrite & (wbAdr == OFS_CTRL);
   assign ctrlRead  = {readyIe_r, busy_r, 1'b0, cmd_r};

   // only the boot lock bits exist, the rest read as one
   function automatic logic [7:0] lockByte(input logic [3:0] locks);
      lockByte = {2'b11, locks, 2'b11};
   endfunction : lockByte

   // bus slave: one wait state, zero for unmapped addresses
   always_comb begin
      ack_nxt = wbCyc & wbStb & ~ack_r;
      dat_nxt = dat_r;
      if (wbCyc & wbStb & ~ack_r) begin
         unique case (wbAdr)
            OFS_CTRL:    dat_nxt = {24'h000000, ctrlRead};
            OFS_LOWDATA: dat_nxt = {24'h000000, lowData_r};
            OFS_HIDATA:  dat_nxt = {24'h000000, highData_r};
            OFS_POINTER: dat_nxt = {16'h0000, pointer_r};
            OFS_IRQSTAT: dat_nxt = {29'h0, stat_r};
            OFS_IRQMASK: dat_nxt = {29'h0, mask_r};
            OFS_LOCKS:   dat_nxt = {24'h000000, lockByte(lock_r)};
            default:     dat_nxt = '0;
         endcase
      end
   end

   // command sequencer
   always_comb begin
      state_nxt    = state_r;
      cmd_nxt      = cmd_r;
      readyIe_nxt  = readyIe_r;
      busy_nxt     = busy_r;
      loading_nxt  = loading_r;
      lock_nxt     = lock_r;
      load_nxt     = load_r;
      loadV_nxt    = 1'b0;
      wr_nxt       = 1'b0;
      er_nxt       = 1'b0;
      bl_nxt       = 1'b0;
      bd_nxt       = 1'b0;
      armStart     = 1'b0;
      armStop      = 1'b0;
      progStart    = 1'b0;
      events       = '0;
      if (ctrlWrite) readyIe_nxt = wbDatIn[CTL_READY_IE];
      // read-enable write aborts a buffer load
      if (ctrlWrite && wbDatIn[CTL_READ_EN] && loading_r) begin
         loading_nxt        = 1'b0;
         bd_nxt             = 1'b1;
         events[EV_ABORT]   = 1'b1;
      end
      unique case (state_r)
         ST_IDLE, ST_ARMED: begin
            if (ctrlWrite && wbDatIn[CTL_CMD_EN]) begin
               cmd_nxt   = wbDatIn[4:0];
               state_nxt = ST_ARMED;
               armStart  = 1'b1;
            end else if (state_r == ST_ARMED && armOpen && storeOp) begin
               armStop = 1'b1;
               cmd_nxt = '0;
               state_nxt = ST_IDLE;
               if (cmd_r[CTL_READ_EN]) begin
                  busy_nxt = 1'b0;
               end else if (cmd_r[CTL_LOCK_SET]) begin
                  // zero data bits program boot locks
                  lock_nxt  = lock_r & lowData_r[LOCK_HI:LOCK_LO];
                  cmd_nxt   = cmd_r;
                  state_nxt = ST_PROG;
                  progStart = 1'b1;
               end else if (cmd_r[CTL_PAGE_WR] | cmd_r[CTL_PAGE_ER]) begin
                  wr_nxt    = cmd_r[CTL_PAGE_WR];
                  er_nxt    = cmd_r[CTL_PAGE_ER] & ~cmd_r[CTL_PAGE_WR];
                  // busy when target is the section
                  if (pointer_r < SECTION_END) busy_nxt = 1'b1;
                  if (cmd_r[CTL_PAGE_WR]) loading_nxt = 1'b0;
                  cmd_nxt   = cmd_r;
                  state_nxt = ST_PROG;
                  progStart = 1'b1;
               end else begin
                  bl_nxt      = 1'b1;
                  loading_nxt = 1'b1;
                  busy_nxt    = 1'b0;
               end
            end else if (state_r == ST_ARMED && !armOpen) begin
               // no store op in the window: disarm all
               cmd_nxt            = '0;
               state_nxt          = ST_IDLE;
               events[EV_TIMEOUT] = 1'b1;
            end
         end
         ST_PROG: begin
            if (progDone) begin
               cmd_nxt         = '0;
               state_nxt       = ST_IDLE;
               events[EV_DONE] = 1'b1;
            end
         end
      endcase
      // lock or fuse readback inside three cycles
      if (loadOp && state_r == ST_ARMED && armOpen && cmd_r[CTL_LOCK_SET]
          && armAge < AGE_W'(LOAD_WINDOW)) begin
         load_nxt  = pointer_r[0] ? lockByte(lock_r) : fuseByte;
         loadV_nxt = 1'b1;
      end
   end

   // data registers, interrupt status and mask, reset vector capture
   always_comb begin
      lowData_nxt  = lowData_r;
      highData_nxt = highData_r;
      pointer_nxt  = pointer_r;
      mask_nxt     = mask_r;
      stat_nxt     = stat_r;
      vector_nxt   = vector_r;
      vecDone_nxt  = 1'b1;
      if (wbWrite && wbAdr == OFS_LOWDATA) lowData_nxt = wbDatIn[7:0];
      if (wbWrite && wbAdr == OFS_HIDATA)  highData_nxt = wbDatIn[7:0];
      if (wbWrite && wbAdr == OFS_POINTER) pointer_nxt = {wbSel[1] ? wbDatIn[15:8] : pointer_r[15:8], wbDatIn[7:0]};
      if (wbWrite && wbAdr == OFS_IRQMASK) mask_nxt = wbDatIn[EV_W-1:0];
      // write one clears, a new event wins
      if (wbWrite && wbAdr == OFS_IRQSTAT) stat_nxt = stat_r & ~wbDatIn[EV_W-1:0];
      stat_nxt = stat_nxt | events;
      // pick the reset vector from the fuse after reset
      if (!vecDone_r) vector_nxt = bootResetFuse ? APP_VECTOR : BOOT_VECTOR;
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state_r    <= ST_IDLE;
         cmd_r      <= CTRL_RESET[4:0];
         readyIe_r  <= CTRL_RESET[CTL_READY_IE];
         busy_r     <= CTRL_RESET[CTL_BUSY];
         loading_r  <= 1'b0;
         lock_r     <= LOCK_RESET;
         load_r     <= 8'h00;
         loadV_r    <= 1'b0;
         wr_r       <= 1'b0;
         er_r       <= 1'b0;
         bl_r       <= 1'b0;
         bd_r       <= 1'b0;
         ack_r      <= 1'b0;
         dat_r      <= '0;
         lowData_r  <= 8'h00;
         highData_r <= 8'h00;
         pointer_r  <= 16'h0000;
         stat_r     <= '0;
         mask_r     <= '0;
         vector_r   <= APP_VECTOR;
         vecDone_r  <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         cmd_r      <= cmd_nxt;
         readyIe_r  <= readyIe_nxt;
         busy_r     <= busy_nxt;
         loading_r  <= loading_nxt;
         lock_r     <= lock_nxt;
         load_r     <= load_nxt;
         loadV_r    <= loadV_nxt;
         wr_r       <= wr_nxt;
         er_r       <= er_nxt;
         bl_r       <= bl_nxt;
         bd_r       <= bd_nxt;
         ack_r      <= ack_nxt;
         dat_r      <= dat_nxt;
         lowData_r  <= lowData_nxt;
         highData_r <= highData_nxt;
         pointer_r  <= pointer_nxt;
         stat_r     <= stat_nxt;
         mask_r     <= mask_nxt;
         vector_r   <= vector_nxt;
         vecDone_r  <= vecDone_nxt;
      end
   end

   spfc_arm_window #(.WINDOW(STORE_WINDOW)) armWin (
      .mclk   (mclk),
      .reset  (reset),
      .start  (armStart),
      .stop   (armStop),
      .isOpen (armOpen),
      .age    (armAge)
   );

   spfc_prog_timer #(.CYCLES(PROG_CYCLES)) progTimer (
      .mclk  (mclk),
      .reset (reset),
      .start (progStart),
      .busy  (progBusy),
      .done  (progDone)
   );

   assign wbAck          = ack_r;
   assign wbDatOut       = dat_r;
   assign loadData       = load_r;
   assign loadValid      = loadV_r;
   assign pageWriteStart = wr_r;
   assign pageEraseStart = er_r;
   assign bufferLoad     = bl_r;
   assign bufferDiscard  = bd_r;
   assign resetVector    = vector_r;
   assign sectionAccessEnable = ~busy_r;
   // ready request plus masked sticky events
   assign irq = (readyIe_r & globalIrqEnable & ~cmd_r[CTL_CMD_EN]) | (|(stat_r & mask_r));

   // checks
   busy_set_a: assert property (@(posedge mclk) disable iff (reset)
      storeOp && state_r == ST_ARMED && armOpen && !ctrlWrite && cmd_r == 5'b00101
      && pointer_r < SECTION_END |=> busy_r && !sectionAccessEnable)
      else $error("section busy not set by page write");
   ready_irq_a: assert property (@(posedge mclk) disable iff (reset)
      readyIe_r && globalIrqEnable && !cmd_r[CTL_CMD_EN] |-> irq)
      else $error("ready interrupt missing");
   resv_zero_a: assert property (@(posedge mclk) disable iff (reset)
      wbAck && wbAdr == OFS_CTRL && !wbWe |-> wbDatOut[CTL_RESV] == 1'b0)
      else $error("reserved control bit read as one");
   prog_hold_a: assert property (@(posedge mclk) disable iff (reset)
      state_r == ST_PROG && !progDone |=> $stable(cmd_r) && cmd_r[CTL_CMD_EN])
      else $error("command bits changed while programming");
   prog_timer_a: assert property (@(posedge mclk) disable iff (reset)
      state_r == ST_PROG |-> progBusy || progDone)
      else $error("programming state without running timer");
   arm_expire_a: assert property (@(posedge mclk) disable iff (reset)
      armStart ##1 (!storeOp && !ctrlWrite) [*5] |=> state_r == ST_IDLE && cmd_r == 5'b00000)
      else $error("armed command outlived its window");
   lock_prog_a: assert property (@(posedge mclk) disable iff (reset)
      storeOp && state_r == ST_ARMED && armOpen && !ctrlWrite && cmd_r == 5'b01001
      |=> lock_r == ($past(lock_r) & $past(lowData_r[LOCK_HI:LOCK_LO])) ##[1:300] state_r == ST_IDLE)
      else $error("boot lock programming wrong");
   read_back_a: assert property (@(posedge mclk) disable iff (reset)
      loadOp && state_r == ST_ARMED && cmd_r[CTL_LOCK_SET] && armAge < AGE_W'(LOAD_WINDOW)
      && armOpen |=> loadValid && loadData == ($past(pointer_r[0]) ? lockByte($past(lock_r)) : $past(fuseByte)))
      else $error("lock or fuse readback wrong");
   load_abort_a: assert property (@(posedge mclk) disable iff (reset)
      ctrlWrite && wbDatIn[CTL_READ_EN] && loading_r |=> bufferDiscard && !loading_r)
      else $error("buffer load not aborted");
   rww_enable_a: assert property (@(posedge mclk) disable iff (reset)
      storeOp && state_r == ST_ARMED && armOpen && !ctrlWrite && cmd_r == 5'b10001
      |=> sectionAccessEnable)
      else $error("section not re-enabled");
   vector_a: assert property (@(posedge mclk) disable iff (reset)
      !vecDone_r |=> resetVector == ($past(bootResetFuse) ? APP_VECTOR : BOOT_VECTOR))
      else $error("reset vector wrong");
   page_write_c: cover property (@(posedge mclk) disable iff (reset) pageWriteStart ##[1:300] progDone);
   lock_set_c:   cover property (@(posedge mclk) disable iff (reset) state_r == ST_PROG && cmd_r[CTL_LOCK_SET]);
   timeout_c:    cover property (@(posedge mclk) disable iff (reset) events[EV_TIMEOUT]);
endmodule : spfc_top
`default_nettype wire

// [hdl/spfc_pkg.sv]
/*
 constants for the self-programming flash control block: register offsets,
 control field positions, reset values and command windows.
 assumes a 32-bit classic wishbone bus with byte addresses and a 100 MHz mclk.
*/
package spfc_pkg;
   localparam int WB_AW = 8;
   localparam int WB_DW = 32;
   // register byte offsets
   localparam logic [WB_AW-1:0] OFS_CTRL    = 8'h00;
   localparam logic [WB_AW-1:0] OFS_LOWDATA = 8'h04;
   localparam logic [WB_AW-1:0] OFS_HIDATA  = 8'h08;
   localparam logic [WB_AW-1:0] OFS_POINTER = 8'h0c;
   localparam logic [WB_AW-1:0] OFS_IRQSTAT = 8'h10;
   localparam logic [WB_AW-1:0] OFS_IRQMASK = 8'h14;
   localparam logic [WB_AW-1:0] OFS_LOCKS   = 8'h18;
   // control register fields
   localparam int CTL_READY_IE = 7;
   localparam int CTL_BUSY     = 6;
   localparam int CTL_RESV     = 5;
   localparam int CTL_READ_EN  = 4;
   localparam int CTL_LOCK_SET = 3;
   localparam int CTL_PAGE_WR  = 2;
   localparam int CTL_PAGE_ER  = 1;
   localparam int CTL_CMD_EN   = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // lock byte: boot lock bits sit in bits 5:2, others read as one
   localparam int LOCK_LO = 2;
   localparam int LOCK_HI = 5;
   localparam logic [3:0] LOCK_RESET = 4'hf;
   // irq status bits
   localparam int EV_DONE    = 0;
   localparam int EV_TIMEOUT = 1;
   localparam int EV_ABORT   = 2;
   localparam int EV_W       = 3;
   // command windows in core clock cycles
   localparam int STORE_WINDOW = 4;
   localparam int LOAD_WINDOW  = 3;
   localparam int AGE_W        = 3;
   localparam logic [15:0] APP_VECTOR = 16'h0000;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_ARMED = 3'b010,
      ST_PROG  = 3'b100
   } spfc_state_t;
endpackage : spfc_pkg

// [hdl/spfc_arm_window.sv]
/*
 counts the cycles since a command was armed and says whether the window is open.
 assumes start and stop are single-cycle pulses in the mclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module spfc_arm_window #(
   parameter int WINDOW = spfc_pkg::STORE_WINDOW
) (
   input  wire logic                       mclk,
   input  wire logic                       reset,
   input  wire logic                       start,
   input  wire logic                       stop,
   output logic                            isOpen,
   output logic [spfc_pkg::AGE_W-1:0]      age
);
   import spfc_pkg::*;
   logic              open_r, open_nxt;
   logic [AGE_W-1:0]  age_r, age_nxt;

   // restart on start, close on stop or when the window runs out
   always_comb begin
      open_nxt = open_r;
      age_nxt  = age_r;
      if (start) begin
         open_nxt = 1'b1;
         age_nxt  = '0;
      end else if (stop) begin
         open_nxt = 1'b0;
      end else if (open_r) begin
         age_nxt = age_r + 1'b1;
         if (age_r == AGE_W'(WINDOW - 1)) open_nxt = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         open_r <= 1'b0;
         age_r  <= '0;
      end else begin
         open_r <= open_nxt;
         age_r  <= age_nxt;
      end
   end

   assign isOpen = open_r;
   assign age    = age_r;
endmodule : spfc_arm_window
`default_nettype wire

// [hdl/spfc_prog_timer.sv]
/*
 stands in for the flash array's programming time: busy for a fixed count.
 assumes start is a single-cycle pulse that only comes while idle.
*/
`timescale 1ns/1ps
`default_nettype none
module spfc_prog_timer #(
   parameter int CYCLES = 16
) (
   input  wire logic mclk,
   input  wire logic reset,
   input  wire logic start,
   output logic      busy,
   output logic      done
);
   logic [15:0] cnt_r, cnt_nxt;
   logic        done_r, done_nxt;

   // count down, pulse done in the cycle after the last busy cycle
   always_comb begin
      cnt_nxt  = cnt_r;
      done_nxt = 1'b0;
      if (start) cnt_nxt = 16'(CYCLES);
      else if (cnt_r != 16'h0000) begin
         cnt_nxt  = cnt_r - 16'h0001;
         done_nxt = (cnt_r == 16'h0001);
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         cnt_r  <= 16'h0000;
         done_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         done_r <= done_nxt;
      end
   end

   assign busy = (cnt_r != 16'h0000);
   assign done = done_r;
endmodule : spfc_prog_timer
`default_nettype wire

// [verif/spfc_core_model.sv]
/*
 stands in for the processor core: one store or load op pulse, a set number of
 cycles after the bench asks for it. assumes the go inputs last one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module spfc_core_model (
   input  wire logic       mclk,
   input  wire logic       reset,
   input  wire logic       goStore,
   input  wire logic       goLoad,
   input  wire logic [2:0] gap,
   output logic            storeOp,
   output logic            loadOp
);
   int   cnt;
   logic kind;
   always @(posedge mclk) begin
      if (reset) begin
         cnt     <= -1;
         storeOp <= 1'b0;
         loadOp  <= 1'b0;
      end else if (goStore || goLoad) begin
         cnt     <= int'(gap) - 1;
         kind    <= goLoad;
         storeOp <= goStore && gap == 3'h0;
         loadOp  <= goLoad && gap == 3'h0;
      end else begin
         storeOp <= cnt == 0 && !kind;
         loadOp  <= cnt == 0 && kind;
         if (cnt >= 0) cnt <= cnt - 1;
      end
   end
endmodule : spfc_core_model
`default_nettype wire

// [verif/spfc_test.sv]
/*
 self-checking bench for the flash control block: wishbone register traffic,
 core op pulses from the core model, pulse counts and readback queue.
 assumes the design answers every bus request and mclk runs at 100 MHz.
*/
`timescale 1ns/1ps
`default_nettype none
module spfc_test;
   import spfc_pkg::*;
   localparam logic [15:0] BOOT_VEC = 16'h0c00;
   logic        mclk = 1'b0, reset = 1'b1, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
   logic [7:0]  wbAdr = 8'h00, fuseByte = 8'h00, lo;
   logic [31:0] wbDatIn = 32'h0, wbDatOut, lfsr = 32'h1d88, q;
   logic        wbAck, storeOp, loadOp, globalIrqEnable = 1'b0, bootResetFuse = 1'b1;
   logic        goStore = 1'b0, goLoad = 1'b0, loadValid, irq, sectionAccessEnable;
   logic        pageWriteStart, pageEraseStart, bufferLoad, bufferDiscard;
   logic [2:0]  gap = 3'h0;
   logic [7:0]  loadData;
   logic [15:0] resetVector;
   int          failures = 0, n_tests = 0, nWr = 0, nLd = 0, nDis = 0, nEr = 0, f;
   logic [7:0]  expLoad[$];
   // 100 MHz clock
   always #5 mclk = ~mclk;
   spfc_top #(.PROG_CYCLES(40), .BOOT_VECTOR(BOOT_VEC), .SECTION_END(16'h1800)) dut_u (
      .mclk(mclk), .reset(reset), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
      .wbSel(4'hf), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck), .storeOp(storeOp),
      .loadOp(loadOp), .globalIrqEnable(globalIrqEnable), .bootResetFuse(bootResetFuse),
      .fuseByte(fuseByte), .loadData(loadData), .loadValid(loadValid),
      .pageWriteStart(pageWriteStart), .pageEraseStart(pageEraseStart), .bufferLoad(bufferLoad),
      .bufferDiscard(bufferDiscard), .sectionAccessEnable(sectionAccessEnable),
      .resetVector(resetVector), .irq(irq));
   spfc_core_model core_u (.mclk(mclk), .reset(reset), .goStore(goStore), .goLoad(goLoad),
      .gap(gap), .storeOp(storeOp), .loadOp(loadOp));
   function automatic logic [31:0] lfsrNext(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsrNext
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one classic cycle, released at the ack edge
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] r);
      int k;
      @(posedge mclk);
      wbCyc   <= 1'b1;
      wbStb   <= 1'b1;
      wbWe    <= we;
      wbAdr   <= adr;
      wbDatIn <= d;
      for (k = 0; k < 20; k++) begin
         @(posedge mclk);
         if (wbAck === 1'b1) break;
      end
      r = wbDatOut;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe  <= 1'b0;
      if (k == 20) begin
         failures++;
         close_out();
      end
   endtask : xfer
   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, adr, d, r);
   endtask : wr
   task automatic chkReg(input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] r;
      xfer(1'b0, adr, 32'h0, r);
      chk(r, exp);
   endtask : chkReg
   // ask the core for an op right after the arming write
   task automatic fire(input logic ld, input logic [2:0] g);
      goStore <= ~ld;
      goLoad  <= ld;
      gap     <= g;
      @(posedge mclk);
      goStore <= 1'b0;
      goLoad  <= 1'b0;
   endtask : fire
   task automatic waitIdle;
      int k;
      for (k = 0; k < 60; k++) begin
         xfer(1'b0, OFS_CTRL, 32'h0, q);
         if (q[CTL_CMD_EN] === 1'b0) break;
      end
      if (k == 60) begin
         failures++;
         close_out();
      end
   endtask : waitIdle
   // pulse counts and readback queue
   always @(posedge mclk) begin
      if (pageWriteStart === 1'b1) nWr++;
      if (bufferLoad === 1'b1) nLd++;
      if (bufferDiscard === 1'b1) nDis++;
      if (pageEraseStart === 1'b1) nEr++;
      if (loadValid === 1'b1) chk({24'h0, loadData}, {24'h0, expLoad.pop_front()});
   end
   initial begin
      lfsr = lfsrNext(lfsr);
      fuseByte = lfsr[15:8];
      // first pass through the loop completes the 12-cycle start-up reset
      repeat (10) @(posedge mclk);
      for (f = 0; f < 2; f++) begin
         bootResetFuse <= f[0];
         reset <= 1'b1;
         repeat (2) @(posedge mclk);
         reset <= 1'b0;
         repeat (3) @(posedge mclk);
         chk({16'h0, resetVector}, f ? {16'h0, APP_VECTOR} : {16'h0, BOOT_VEC});
      end
      chkReg(OFS_CTRL, 32'h0);
      wr(OFS_CTRL, 32'he0);
      chkReg(OFS_CTRL, 32'h80);
      wr(8'h20, 32'h55);
      chkReg(8'h20, 32'h0);
      globalIrqEnable <= 1'b1;
      repeat (2) @(posedge mclk);
      chk({31'h0, irq}, 32'h1);
      globalIrqEnable <= 1'b0;
      wr(OFS_CTRL, 32'h00);
      $display("test registers done");
      lfsr = lfsrNext(lfsrNext(lfsr));
      lo = lfsr[7:0];
      wr(OFS_LOWDATA, {24'h0, lo});
      wr(OFS_CTRL, 32'h09);
      fire(1'b0, 3'h2);
      waitIdle();
      chkReg(OFS_CTRL, 32'h0);
      chkReg(OFS_LOCKS, {24'h0, 2'b11, lo[5:2], 2'b11});
      chkReg(OFS_IRQSTAT, 32'h1);
      wr(OFS_IRQMASK, 32'h1);
      repeat (2) @(posedge mclk);
      chk({31'h0, irq}, 32'h1);
      wr(OFS_IRQSTAT, 32'h1);
      chkReg(OFS_IRQSTAT, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(OFS_IRQMASK, 32'h0);
      $display("test lock set done");
      for (f = 0; f < 2; f++) begin
         wr(OFS_POINTER, f);
         expLoad.push_back(f ? {2'b11, lo[5:2], 2'b11} : fuseByte);
         wr(OFS_CTRL, 32'h09);
         fire(1'b1, 3'h0);
         repeat (8) @(posedge mclk);
         chk(expLoad.size(), 0);
         chkReg(OFS_CTRL, 32'h0);
      end
      chkReg(OFS_IRQSTAT, 32'h2);
      wr(OFS_IRQSTAT, 32'h7);
      for (f = 0; f < 2; f++) begin
         wr(OFS_CTRL, f ? 32'h11 : 32'h05);
         repeat (8) @(posedge mclk);
         chkReg(OFS_CTRL, 32'h0);
      end
      $display("test readback done");
      wr(OFS_POINTER, 32'h0010);
      wr(OFS_CTRL, 32'h05);
      fire(1'b0, 3'h1);
      repeat (3) @(posedge mclk);
      chk({31'h0, sectionAccessEnable}, 32'h0);
      chkReg(OFS_CTRL, 32'h45);
      wr(OFS_CTRL, 32'h11);
      chkReg(OFS_CTRL, 32'h45);
      waitIdle();
      chkReg(OFS_CTRL, 32'h40);
      chk(nWr, 1);
      wr(OFS_CTRL, 32'h01);
      fire(1'b0, 3'h0);
      repeat (3) @(posedge mclk);
      chk({31'h0, sectionAccessEnable}, 32'h1);
      chk(nLd, 1);
      wr(OFS_CTRL, 32'h11);
      repeat (8) @(posedge mclk);
      chk(nDis, 1);
      xfer(1'b0, OFS_IRQSTAT, 32'h0, q);
      chk(q & 32'h4, 32'h4);
      wr(OFS_CTRL, 32'h05);
      fire(1'b0, 3'h0);
      waitIdle();
      chk({31'h0, sectionAccessEnable}, 32'h0);
      wr(OFS_CTRL, 32'h11);
      fire(1'b0, 3'h2);
      repeat (4) @(posedge mclk);
      chk({31'h0, sectionAccessEnable}, 32'h1);
      chkReg(OFS_CTRL, 32'h0);
      // page erase just above the tracked section leaves it readable
      wr(OFS_POINTER, 32'h1800);
      wr(OFS_CTRL, 32'h03);
      fire(1'b0, 3'h0);
      waitIdle();
      chk(nEr, 1);
      chk({31'h0, sectionAccessEnable}, 32'h1);
      $display("test section busy done");
      close_out();
   end
endmodule : spfc_test
`default_nettype wire
